// ### design/pmm_fifo.sv
// synchronous fifo, valid/ready on both sides
// assumes both sides on clk; no bypass, so one cycle write-to-read
`timescale 1ns/1ps
`default_nettype none
module pmm_fifo #(
  parameter int unsigned W = 10,
  parameter int unsigned D = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [W-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [W-1:0] rd_data
);
  localparam int unsigned AW = $clog2(D);

  logic [W-1:0] mem_ff [D];
  logic [AW:0] wp_ff;
  logic [AW:0] rp_ff;
  logic do_wr;
  logic do_rd;

  assign wr_ready = (wp_ff[AW-1:0] != rp_ff[AW-1:0]) || (wp_ff[AW] == rp_ff[AW]);
  assign rd_valid = wp_ff != rp_ff;
  assign rd_data = mem_ff[rp_ff[AW-1:0]];
  assign do_wr = wr_valid & wr_ready;
  assign do_rd = rd_valid & rd_ready;

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_ff[wp_ff[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      wp_ff <= wp_ff + (AW+1)'(do_wr);
      rp_ff <= rp_ff + (AW+1)'(do_rd);
    end
  end
endmodule // pmm_fifo
`default_nettype wire

// ### design/pmm_pkg.sv
// constants and carrier types for the shared-pin network port block
// assumes one 25 MHz system clock; all pin timing is sampled on it
package pmm_pkg;

  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned MDC_MAX_HZ = 2_500_000;
  // half period of the management clock, least time rounded up
  localparam logic [3:0] MDC_HALF_CYC =
    4'((CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ));

  // management frame: preamble, then 32 frame bits msb first
  localparam logic [5:0] MG_PRE_BITS = 6'h20;
  localparam logic [5:0] MG_LAST_BIT = 6'h3F;
  localparam logic [5:0] MG_TURN_BIT = 6'h2E;
  localparam logic [5:0] MG_CAP_BIT = 6'h30;

  localparam int unsigned FIFO_DEPTH = 8;

  // receive status word field positions
  localparam int unsigned ST_CRC_ERR = 0;
  localparam int unsigned ST_COLL = 1;
  localparam int unsigned ST_DRIBBLE = 2;
  localparam int unsigned ST_OVERFLOW = 3;

  localparam logic RST_LOW = 1'b0;

  typedef enum logic [1:0] {
    TAG_DATA = 2'b00,
    TAG_STATUS = 2'b01,
    TAG_SYMBOL = 2'b10
  } pmm_tag_e;

  typedef enum logic {
    MG_IDLE = 1'b0,
    MG_RUN = 1'b1
  } pmm_mg_state_e;

  typedef struct packed {
    pmm_tag_e tag;
    logic [7:0] payload;
  } pmm_rx_word_s;

  localparam int unsigned FIFO_WIDTH = $bits(pmm_rx_word_s);

  // pin inputs that cross into the clk domain together
  typedef struct packed {
    logic link;
    logic mdio;
    logic tclk;
    logic rx_err;
    logic dv;
    logic crs;
    logic clsn;
    logic [3:0] rxd;
    logic rclk;
  } pmm_pins_s;

endpackage

// ### design/pmm_port_mux.sv
// shared-pin network port: nibble mode / symbol mode, management clock and data
// assumes pins arrive asynchronous to clk; link clocks far slower than clk
//
// Contract
// - nibble mode when port select is 1 and symbol mode is 0, symbol mode when both are 1.
// - in nibble mode the shared collision pin is an input whose assertion means collision.
// - the sense pin means carrier sense in nibble mode and signal detect in symbol mode.
// - the block sources the management clock as reference for every management transfer.
// - the management data line is two-way, commands out and status back.
// - with a nibble-mode partner a high link status input means link pass.
// - in symbol mode the receive error pin drives speed select, 1 for 100 Mb/s, 0 for 10 Mb/s.
// - receive error during a nibble-mode packet sets the CRC error flag in its status word.
// - transmit enable flags transmission in nibble mode and is symbol bit four in symbol mode.
`timescale 1ns/1ps
`default_nettype none
module pmm_port_mux (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic port_select_bit,
  input wire logic symbol_mode_bit,
  input wire logic rx_clk_pin,
  input wire logic [3:0] rxd_pin,
  input wire logic clsn_or_rxd4,
  input wire logic carrier_or_signal_detect,
  input wire logic receive_data_valid,
  input wire logic rx_error_or_speed_in,
  output logic rx_error_or_speed_out,
  output logic rx_error_or_speed_oe,
  input wire logic tx_clk_pin,
  output logic [3:0] txd_pin,
  output logic txen_or_txd4,
  output logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic link_status_pin,
  output logic collision,
  output logic carrier_sense,
  output logic signal_detect,
  output logic link_pass,
  output logic rx_valid,
  input wire logic rx_ready,
  output pmm_pkg::pmm_rx_word_s rx_word,
  input wire logic tx_valid,
  input wire logic [4:0] tx_symbol,
  output logic tx_ready,
  input wire logic mgmt_start,
  input wire logic mgmt_read,
  input wire logic [31:0] mgmt_word,
  output logic mgmt_busy,
  output logic mgmt_done,
  output logic [15:0] mgmt_rdata
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and mode decode

  pmm_pkg::pmm_pins_s pins_in;
  pmm_pkg::pmm_pins_s s1_ff;
  pmm_pkg::pmm_pins_s s2_ff;
  logic rclk_d_ff;
  logic tclk_d_ff;

  assign pins_in = '{link: link_status_pin, mdio: mdio_in, tclk: tx_clk_pin,
                     rx_err: rx_error_or_speed_in, dv: receive_data_valid,
                     crs: carrier_or_signal_detect, clsn: clsn_or_rxd4,
                     rxd: rxd_pin, rclk: rx_clk_pin};

  always_ff @(posedge clk) begin
    s1_ff <= pins_in;
    s2_ff <= s1_ff;
    rclk_d_ff <= s2_ff.rclk;
    tclk_d_ff <= s2_ff.tclk;
  end

  wire mii_mode = port_select_bit & ~symbol_mode_bit;
  wire sym_mode = port_select_bit & symbol_mode_bit;
  // sample mid-bit: partner launches on the rising edge
  wire rclk_fall = rclk_d_ff & ~s2_ff.rclk;
  wire tclk_fall = tclk_d_ff & ~s2_ff.tclk;

  //////////////////////////////////////////////////////////////////////////////
  // pin meaning per mode

  logic coll_ff;
  logic crs_ff;
  logic sd_ff;
  logic link_ff;
  logic spd_ff;
  logic spd_oe_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      coll_ff <= pmm_pkg::RST_LOW;
      crs_ff <= pmm_pkg::RST_LOW;
      sd_ff <= pmm_pkg::RST_LOW;
      link_ff <= pmm_pkg::RST_LOW;
      spd_ff <= pmm_pkg::RST_LOW;
      spd_oe_ff <= pmm_pkg::RST_LOW;
    end else begin
      coll_ff <= mii_mode & s2_ff.clsn;
      crs_ff <= mii_mode & s2_ff.crs;
      sd_ff <= sym_mode & s2_ff.crs;
      link_ff <= mii_mode & s2_ff.link;
      spd_ff <= symbol_mode_bit & port_select_bit;
      spd_oe_ff <= symbol_mode_bit;
    end
  end

  assign collision = coll_ff;
  assign carrier_sense = crs_ff;
  assign signal_detect = sd_ff;
  assign link_pass = link_ff;
  assign rx_error_or_speed_out = spd_ff;
  assign rx_error_or_speed_oe = spd_oe_ff;

  //////////////////////////////////////////////////////////////////////////////
  // receive assembly into the fifo

  logic in_pkt_ff;
  logic nib_hi_ff;
  logic [3:0] lo_nib_ff;
  logic crc_err_ff;
  logic pkt_coll_ff;
  logic ovf_ff;
  logic pend_ff;
  logic [7:0] stat_ff;
  logic fifo_wr_ready;
  pmm_pkg::pmm_rx_word_s fifo_in;

  wire mii_smp = rclk_fall & mii_mode;
  wire sym_smp = rclk_fall & sym_mode & s2_ff.crs;
  wire byte_push = mii_smp & s2_ff.dv & nib_hi_ff;
  wire pkt_end = mii_smp & in_pkt_ff & ~s2_ff.dv;
  wire data_push = byte_push | sym_smp;
  // a pending status word owns the write port; colliding data is dropped
  wire data_lost = data_push & (pend_ff | ~fifo_wr_ready);
  wire fifo_wr_valid = pend_ff | data_push;
  wire [7:0] sym_byte = {3'h0, s2_ff.clsn, s2_ff.rxd};
  wire [7:0] nxt_stat = {4'h0, ovf_ff | data_lost, nib_hi_ff, pkt_coll_ff, crc_err_ff};

  assign fifo_in.tag = pend_ff ? pmm_pkg::TAG_STATUS :
                       (sym_smp ? pmm_pkg::TAG_SYMBOL : pmm_pkg::TAG_DATA);
  assign fifo_in.payload = pend_ff ? stat_ff :
                           (sym_smp ? sym_byte : {s2_ff.rxd, lo_nib_ff});

  always_ff @(posedge clk) begin
    if (!rst_n || !mii_mode) begin
      in_pkt_ff <= pmm_pkg::RST_LOW;
      nib_hi_ff <= pmm_pkg::RST_LOW;
      crc_err_ff <= pmm_pkg::RST_LOW;
      pkt_coll_ff <= pmm_pkg::RST_LOW;
    end else if (mii_smp) begin
      in_pkt_ff <= s2_ff.dv;
      nib_hi_ff <= s2_ff.dv & ~nib_hi_ff;
      crc_err_ff <= s2_ff.dv & (crc_err_ff | s2_ff.rx_err);
      pkt_coll_ff <= s2_ff.dv & (pkt_coll_ff | s2_ff.clsn);
    end
  end

  always_ff @(posedge clk) begin
    if (mii_smp & ~nib_hi_ff) begin
      lo_nib_ff <= s2_ff.rxd;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ovf_ff <= pmm_pkg::RST_LOW;
      pend_ff <= pmm_pkg::RST_LOW;
      stat_ff <= 8'h00;
    end else begin
      ovf_ff <= ~pkt_end & ~(mii_smp & ~in_pkt_ff) & (ovf_ff | data_lost);
      if (pkt_end) begin
        pend_ff <= 1'b1;
        stat_ff <= nxt_stat;
      end else if (fifo_wr_ready) begin
        pend_ff <= 1'b0;
      end
    end
  end

  pmm_fifo #(
    .W(pmm_pkg::FIFO_WIDTH),
    .D(pmm_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .wr_valid(fifo_wr_valid),
    .wr_ready(fifo_wr_ready),
    .wr_data(fifo_in),
    .rd_valid(rx_valid),
    .rd_ready(rx_ready),
    .rd_data(rx_word)
  );

  //////////////////////////////////////////////////////////////////////////////
  // transmit: launch on falling edge so the partner's rising edge sees stable data

  logic [3:0] txd_ff;
  logic txen_ff;

  wire tx_take = tclk_fall & tx_valid & (mii_mode | sym_mode);
  assign tx_ready = tx_take;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txd_ff <= 4'h0;
      txen_ff <= pmm_pkg::RST_LOW;
    end else if (tclk_fall) begin
      txd_ff <= tx_take ? tx_symbol[3:0] : 4'h0;
      txen_ff <= tx_take & (mii_mode | tx_symbol[4]);
    end
  end

  assign txd_pin = txd_ff;
  assign txen_or_txd4 = txen_ff;

  //////////////////////////////////////////////////////////////////////////////
  // management clock and data engine

  pmm_pkg::pmm_mg_state_e mg_st_ff;
  logic [3:0] div_ff;
  logic mdc_ff;
  logic [5:0] cnt_ff;
  logic [31:0] sh_ff;
  logic rd_ff;
  logic mdo_ff;
  logic mdoe_ff;
  logic done_ff;
  logic [15:0] rdata_ff;

  wire mg_run = mg_st_ff == pmm_pkg::MG_RUN;
  wire tick = mg_run & (div_ff == pmm_pkg::MDC_HALF_CYC - 4'h1);
  wire rise = tick & ~mdc_ff;
  wire fall = tick & mdc_ff;
  wire last = cnt_ff == pmm_pkg::MG_LAST_BIT;
  wire in_frame = cnt_ff >= pmm_pkg::MG_PRE_BITS;
  wire [5:0] nxt_cnt = cnt_ff + 6'h01;
  wire nxt_bit = (nxt_cnt < pmm_pkg::MG_PRE_BITS) | (in_frame ? sh_ff[30] : sh_ff[31]);
  // reads release the line from the turnaround on
  wire nxt_oe = ~(rd_ff & (nxt_cnt >= pmm_pkg::MG_TURN_BIT));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mg_st_ff <= pmm_pkg::MG_IDLE;
      div_ff <= 4'h0;
      mdc_ff <= pmm_pkg::RST_LOW;
      cnt_ff <= 6'h00;
      mdo_ff <= pmm_pkg::RST_LOW;
      mdoe_ff <= pmm_pkg::RST_LOW;
      done_ff <= pmm_pkg::RST_LOW;
    end else begin
      done_ff <= fall & last;
      div_ff <= tick | ~mg_run ? 4'h0 : div_ff + 4'h1;
      unique case (mg_st_ff)
        pmm_pkg::MG_IDLE: begin
          if (mgmt_start) begin
            mg_st_ff <= pmm_pkg::MG_RUN;
            cnt_ff <= 6'h00;
            mdo_ff <= 1'b1;
            mdoe_ff <= 1'b1;
          end
        end
        pmm_pkg::MG_RUN: begin
          if (tick) begin
            mdc_ff <= ~mdc_ff;
          end
          if (fall & last) begin
            mg_st_ff <= pmm_pkg::MG_IDLE;
            mdoe_ff <= 1'b0;
          end else if (fall) begin
            cnt_ff <= nxt_cnt;
            mdo_ff <= nxt_bit;
            mdoe_ff <= nxt_oe;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!mg_run & mgmt_start) begin
      sh_ff <= mgmt_word;
      rd_ff <= mgmt_read;
    end else if (fall & in_frame) begin
      sh_ff <= {sh_ff[30:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_ff <= 16'h0000;
    end else if (rise & rd_ff & (cnt_ff >= pmm_pkg::MG_CAP_BIT)) begin
      rdata_ff <= {rdata_ff[14:0], s2_ff.mdio};
    end
  end

  assign mdc = mdc_ff;
  assign mdio_out = mdo_ff;
  assign mdio_oe = mdoe_ff;
  assign mgmt_busy = mg_run;
  assign mgmt_done = done_ff;
  assign mgmt_rdata = rdata_ff;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_mdc_high;
    mdc [*5] ##1 !mdc;
  endsequence

  property p_mode_excl;
    // collision is registered, so it may stand one cycle past a mode change
    !(carrier_sense && signal_detect) and (symbol_mode_bit |=> !collision);
  endproperty
  a_mode_excl: assert property (p_mode_excl) else $error("mode pins mixed");

  property p_speed_out;
    sym_mode |=> rx_error_or_speed_oe && rx_error_or_speed_out;
  endproperty
  a_speed_out: assert property (p_speed_out) else $error("speed select wrong");

  property p_coll;
    mii_mode && s2_ff.clsn |=> collision;
  endproperty
  a_coll: assert property (p_coll) else $error("collision missed");

  property p_sym_push;
    sym_smp && !pend_ff && fifo_wr_ready |->
      fifo_wr_valid && fifo_in.payload[4] == s2_ff.clsn;
  endproperty
  a_sym_push: assert property (p_sym_push) else $error("symbol bit four lost");

  property p_crc;
    mii_smp && s2_ff.dv && s2_ff.rx_err |=> crc_err_ff;
  endproperty
  a_crc: assert property (p_crc) else $error("crc flag not set");

  property p_stat_word;
    pkt_end |=> pend_ff && stat_ff[pmm_pkg::ST_CRC_ERR] == $past(crc_err_ff);
  endproperty
  a_stat_word: assert property (p_stat_word) else $error("status word wrong");

  property p_mdc_period;
    $rose(mdc) |-> s_mdc_high;
  endproperty
  a_mdc_period: assert property (p_mdc_period) else $error("mdc half period");

  property p_mdio_release;
    mg_run && rd_ff && cnt_ff >= pmm_pkg::MG_TURN_BIT |-> !mdio_oe;
  endproperty
  a_mdio_release: assert property (p_mdio_release) else $error("mdio driven on read");

  property p_link;
    mii_mode && s2_ff.link |=> link_pass;
  endproperty
  a_link: assert property (p_link) else $error("link pass missed");

  property p_tx;
    tclk_fall && tx_valid && mii_mode |=> txen_or_txd4 && txd_pin == $past(tx_symbol[3:0]);
  endproperty
  a_tx: assert property (p_tx) else $error("transmit enable wrong");

  property p_idle_quiet;
    !mii_mode && !sym_mode |-> !data_push ##1 !in_pkt_ff;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("inactive mode leaked");

endmodule // pmm_port_mux
`default_nettype wire

// ### dv/pmm_phy_model.sv
// partner model: receive device, free transmit clock, management responder
// assumes the bench calls rx_frame and joins mdio_drv into the wire as a pull-up
`timescale 1ns/1ps
`default_nettype none
module pmm_phy_model #(
  parameter logic [15:0] RD_PAT = 16'hC35A
) (
  output logic rclk,
  output logic [3:0] rxd,
  output logic clsn,
  output logic crs,
  output logic dv,
  output logic rx_err,
  output logic tclk,
  output logic mdio_drv,
  input wire logic mdc,
  input wire logic mdio_oe
);
  int nb;
  initial begin
    {rclk, rxd, clsn, crs, dv, rx_err} = '0;
    tclk = 1'h0;
    nb = 99;
  end
  // transmit clock runs free, 320 ns
  always #160 tclk = ~tclk;
  ////////////////////////////////////////////////////////////////////////////
  // launch on rising edge; clock stands still between frames
  task automatic rx_frame(input logic [4:0] q[$], input logic [31:0] err,
                          input logic sym, input logic col);
    foreach (q[i]) begin
      rclk = 1'h1;
      rxd = q[i][3:0];
      clsn = sym ? q[i][4] : col;
      crs = 1'h1;
      dv = !sym;
      rx_err = err[i];
      #160 rclk = 1'h0;
      #160;
    end
    rclk = 1'h1;
    {dv, crs, clsn, rx_err} = '0;
    #160 rclk = 1'h0;
    #160 rxd = ~rxd;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // bit count from frame start; second turnaround bit low, then pattern msb first
  always @(posedge mdio_oe) nb = 0;
  always @(negedge mdc) nb = nb + 1;
  assign mdio_drv = (!mdio_oe && nb >= 47 && nb <= 63) ?
    (nb == 47 ? 1'h0 : RD_PAT[63 - nb]) : 1'h1;
endmodule // pmm_phy_model
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the shared-pin port block
// assumes pmm_phy_model as far side; mdio and rx error pins resolved here
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [15:0] RD_PAT = 16'hC35A;
  logic clk = 1'h0, rst_n = 1'h0, port_select_bit = 1'h0, symbol_mode_bit = 1'h0;
  logic rx_ready = 1'h0, tx_valid = 1'h0, mgmt_start = 1'h0, mgmt_read = 1'h0;
  logic link_status_pin = 1'h0;
  logic [4:0] tx_symbol = 5'h00;
  logic [31:0] mgmt_word = 32'h00000000;
  logic rclk, clsn, crs, dv, rx_err, tclk, mdio_drv, mdc, mdio_out, mdio_oe;
  logic rx_error_or_speed_out, rx_error_or_speed_oe, txen_or_txd4, tx_ready;
  logic collision, carrier_sense, signal_detect, link_pass, rx_valid;
  logic mgmt_busy, mgmt_done;
  logic [3:0] rxd, txd_pin;
  logic [15:0] mgmt_rdata;
  logic [63:0] sh = 64'h0;
  pmm_pkg::pmm_rx_word_s rx_word;
  int failures = 0, check_count = 0, cycles = 0;
  // two-way pins: whoever enables drives, else the far side or pull-up
  wire logic mdio_line = mdio_oe ? mdio_out : mdio_drv;
  wire logic err_line = rx_error_or_speed_oe ? rx_error_or_speed_out : rx_err;

  pmm_port_mux i_pmm_port_mux (.clk(clk), .rst_n(rst_n), .port_select_bit(port_select_bit),
    .symbol_mode_bit(symbol_mode_bit), .rx_clk_pin(rclk), .rxd_pin(rxd), .clsn_or_rxd4(clsn),
    .carrier_or_signal_detect(crs), .receive_data_valid(dv), .rx_error_or_speed_in(err_line),
    .rx_error_or_speed_out(rx_error_or_speed_out), .rx_error_or_speed_oe(rx_error_or_speed_oe),
    .tx_clk_pin(tclk), .txd_pin(txd_pin), .txen_or_txd4(txen_or_txd4), .mdc(mdc),
    .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .link_status_pin(link_status_pin), .collision(collision), .carrier_sense(carrier_sense),
    .signal_detect(signal_detect), .link_pass(link_pass), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_word(rx_word), .tx_valid(tx_valid), .tx_symbol(tx_symbol),
    .tx_ready(tx_ready), .mgmt_start(mgmt_start), .mgmt_read(mgmt_read),
    .mgmt_word(mgmt_word), .mgmt_busy(mgmt_busy), .mgmt_done(mgmt_done),
    .mgmt_rdata(mgmt_rdata));
  pmm_phy_model #(.RD_PAT(RD_PAT)) i_pmm_phy_model (.rclk(rclk), .rxd(rxd), .clsn(clsn),
    .crs(crs), .dv(dv), .rx_err(rx_err), .tclk(tclk), .mdio_drv(mdio_drv), .mdc(mdc),
    .mdio_oe(mdio_oe));
  ////////////////////////////////////////////////////////////////////////////
  always #20 clk = ~clk;
  // wire level at each management clock rise; last 64 form the frame
  always @(posedge mdc) sh <= {sh[62:0], mdio_line};
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // every task starts and ends 1 ns after a rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic set_mode(input logic p, input logic s);
    port_select_bit = p;
    symbol_mode_bit = s;
    cyc(4);
  endtask
  task automatic pop(input logic [9:0] exp);
    int n;
    n = 0;
    while (rx_valid !== 1'h1 && n < 300) begin
      cyc(1);
      n++;
    end
    check({rx_valid, rx_word}, {1'h1, exp});
    rx_ready = 1'h1;
    cyc(1);
    rx_ready = 1'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_nibble();
    set_mode(1'h1, 1'h0);
    fork
      i_pmm_phy_model.rx_frame('{5'h05, 5'h0A, 5'h03, 5'h0C}, 32'h2, 1'h0, 1'h1);
      begin
        cyc(20);
        check({collision, carrier_sense, signal_detect}, 3'h6);
      end
    join
    cyc(10);
    pop({pmm_pkg::TAG_DATA, 8'hA5});
    pop({pmm_pkg::TAG_DATA, 8'hC3});
    pop({pmm_pkg::TAG_STATUS, 8'h03});
    i_pmm_phy_model.rx_frame('{5'h01, 5'h02, 5'h03}, 32'h0, 1'h0, 1'h0);
    cyc(10);
    pop({pmm_pkg::TAG_DATA, 8'h21});
    pop({pmm_pkg::TAG_STATUS, 8'h04});
    check(rx_valid, 1'h0);
  endtask
  // dv stays low in symbol mode; words must still arrive, no status
  task automatic t_symbol();
    set_mode(1'h1, 1'h1);
    check({rx_error_or_speed_out, rx_error_or_speed_oe}, 2'h3);
    fork
      i_pmm_phy_model.rx_frame('{5'h15, 5'h0A, 5'h1F}, 32'h0, 1'h1, 1'h0);
      begin
        cyc(20);
        check({collision, carrier_sense, signal_detect}, 3'h1);
      end
    join
    cyc(10);
    pop({pmm_pkg::TAG_SYMBOL, 8'h15});
    pop({pmm_pkg::TAG_SYMBOL, 8'h0A});
    pop({pmm_pkg::TAG_SYMBOL, 8'h1F});
    check(rx_valid, 1'h0);
    set_mode(1'h0, 1'h1);
    check({rx_error_or_speed_out, rx_error_or_speed_oe}, 2'h1);
  endtask
  // ten bytes into eight slots while the consumer stalls
  task automatic t_overflow();
    logic [4:0] q[$];
    set_mode(1'h1, 1'h0);
    for (int i = 0; i < 20; i++) q.push_back(5'(i % 16));
    i_pmm_phy_model.rx_frame(q, 32'h0, 1'h0, 1'h0);
    cyc(10);
    check(rx_valid, 1'h1);
    for (int k = 0; k < 8; k++) pop({pmm_pkg::TAG_DATA, 4'(2 * k + 1), 4'(2 * k)});
    pop({pmm_pkg::TAG_STATUS, 8'h08});
    check(rx_valid, 1'h0);
  endtask
  // exp[5] says whether the symbol is taken, exp[4:0] the pins after
  task automatic t_tx(input logic p, input logic s, input logic [4:0] sym,
                      input logic [5:0] exp);
    int n;
    set_mode(p, s);
    tx_symbol = sym;
    tx_valid = 1'h1;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (tx_ready !== 1'h1 && n < 40);
    check(n < 40, exp[5]);
    cyc(1);
    tx_valid = 1'h0;
    if (exp[5]) check({txen_or_txd4, txd_pin}, exp[4:0]);
  endtask
  // a second start while busy must be ignored
  task automatic t_mgmt(input logic rd, input logic [31:0] w);
    int n;
    mgmt_read = rd;
    mgmt_word = w;
    mgmt_start = 1'h1;
    cyc(1);
    check(mgmt_busy, 1'h1);
    cyc(1);
    mgmt_start = 1'h0;
    n = 0;
    while (mgmt_done !== 1'h1 && n < 900) begin
      cyc(1);
      n++;
    end
    check(n < 900, 1'h1);
    check(sh, {32'hFFFFFFFF, rd ? {w[31:18], 2'h2, RD_PAT} : w});
    if (rd) check(mgmt_rdata, RD_PAT);
    cyc(30);
    check({mgmt_busy, mdio_oe}, 2'h0);
  endtask
  task automatic t_link();
    set_mode(1'h1, 1'h0);
    link_status_pin = 1'h1;
    cyc(6);
    check(link_pass, 1'h1);
    link_status_pin = 1'h0;
    cyc(6);
    check(link_pass, 1'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(5);
    rst_n = 1'h1;
    cyc(1);
    check({mdc, mdio_oe, rx_valid, mgmt_busy, txd_pin}, 8'h00);
    cyc(3);
    t_nibble();
    t_symbol();
    t_overflow();
    t_tx(1'h1, 1'h0, 5'h0A, 6'h3A);
    t_tx(1'h1, 1'h1, 5'h0C, 6'h2C);
    t_tx(1'h1, 1'h1, 5'h15, 6'h35);
    t_tx(1'h0, 1'h0, 5'h1F, 6'h00);
    t_mgmt(1'h0, 32'h5A3C0F96);
    t_mgmt(1'h1, 32'h6F8A0000);
    t_link();
    summarize();
  end
endmodule // testbench
`default_nettype wire
